/* File: shared/fbsc_pkg.sv */
// Package for the fieldbus state and configuration controller.
// Assumes one core clock domain and a host that presents object writes
// and state requests as single-cycle strobes.
package fbsc_pkg;

  // Host link states, one-hot.
  typedef enum logic [3:0] {
    FBSC_ST_INIT   = 4'b0001,
    FBSC_ST_PREOP  = 4'b0010,
    FBSC_ST_SAFEOP = 4'b0100,
    FBSC_ST_OP     = 4'b1000
  } fbsc_link_type;

  // Object indices.
  localparam logic [15:0] OBJ_GENERAL    = 16'hf800;
  localparam logic [15:0] OBJ_SLAVE_BASE = 16'h8000;
  localparam logic [15:0] OBJ_SLAVE_MASK = 16'hff0f;
  localparam logic [15:0] OBJ_PDO_OUT    = 16'h1c12;
  localparam logic [15:0] OBJ_PDO_IN     = 16'h1c13;
  localparam logic [7:0]  SUB_ADDR       = 8'h01;
  localparam logic [7:0]  SUB_BAUD       = 8'h02;

  // Address and baud setting command.
  localparam logic [19:0] CMD_INDEX_GROUP = 20'h1f480;
  localparam logic [31:0] CMD_OFFSET      = 32'h0000_0000;
  localparam logic [7:0]  CMD_LEN         = 8'h06;
  localparam logic [7:0]  CMD_KEY0        = 8'h45;
  localparam logic [7:0]  CMD_KEY1        = 8'h23;
  localparam logic [7:0]  ADDR_MAX        = 8'h3f;
  localparam logic [7:0]  BAUD_500K       = 8'h01;
  localparam logic [7:0]  BAUD_125K       = 8'h03;
  localparam logic [47:0] CMD_ERASE       = 48'h0000_0000_0000;

  // Fieldbus service codes for attribute access.
  localparam logic [7:0]  SVC_GET_SINGLE  = 8'h0e;
  localparam logic [7:0]  SVC_SET_SINGLE  = 8'h10;

  // Message access kinds.
  localparam logic [1:0]  ACC_READ   = 2'b00;
  localparam logic [1:0]  ACC_WRITE  = 2'b01;
  localparam logic [1:0]  ACC_SVC    = 2'b10;

endpackage : fbsc_pkg

/* File: rtl/fbsc_addr_cmd.sv */
// Decoder and persistent store for the address and baud command.
// Assumes the persistent store is modelled by flip-flops kept over rst.
`timescale 1ns/1ps
`default_nettype none
module fbsc_addr_cmd
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        cmd_valid,
  input  wire logic [19:0] command_index_group,
  input  wire logic [31:0] cmd_offset,
  input  wire logic [7:0]  cmd_len,
  input  wire logic [47:0] cmd_data,
  output logic             cmd_ok,
  output logic             cmd_bad,
  output logic             stored_valid_r,
  output logic [7:0]       stored_addr_r,
  output logic [7:0]       stored_baud_r
);

  logic [7:0] b0;
  logic [7:0] b1;
  logic [7:0] b2;
  logic [7:0] b3;
  logic [7:0] b4;
  logic [7:0] b5;
  logic       hit;
  logic       erase;
  logic       set_ok;
  logic       keep_valid_r = 1'b0;
  logic [7:0] keep_addr_r  = 8'h00;
  logic [7:0] keep_baud_r  = 8'h00;

  assign b0 = cmd_data[7:0];
  assign b1 = cmd_data[15:8];
  assign b2 = cmd_data[23:16];
  assign b3 = cmd_data[31:24];
  assign b4 = cmd_data[39:32];
  assign b5 = cmd_data[47:40];
  assign hit = cmd_valid && command_index_group == fbsc_pkg::CMD_INDEX_GROUP
             && cmd_offset == fbsc_pkg::CMD_OFFSET
             && cmd_len == fbsc_pkg::CMD_LEN;
  assign erase = hit && cmd_data == fbsc_pkg::CMD_ERASE;
  assign set_ok = hit && b0 == fbsc_pkg::CMD_KEY0 && b1 == fbsc_pkg::CMD_KEY1
                && b2 <= fbsc_pkg::ADDR_MAX
                && b4 >= fbsc_pkg::BAUD_500K
                && b4 <= fbsc_pkg::BAUD_125K
                && b3 == 8'h00 && b5 == 8'h00;
  assign cmd_ok  = set_ok || erase;
  assign cmd_bad = hit && !cmd_ok;

  // The store ignores rst on purpose, since it stands for nonvolatile data.
  // Its power-up value is the empty delivery state.
  always_ff @(posedge core_clk)
  begin
    if (erase)
    begin
      keep_valid_r <= 1'b0;
    end
    else if (set_ok)
    begin
      keep_valid_r <= 1'b1;
      keep_addr_r  <= b2;
      keep_baud_r  <= b4;
    end
  end

  assign stored_valid_r = keep_valid_r;
  assign stored_addr_r  = keep_addr_r;
  assign stored_baud_r  = keep_baud_r;

  a_erase_store : assert property (@(posedge core_clk)
    erase |=> !stored_valid_r)
    else $error("Stored setting not erased.");

endmodule : fbsc_addr_cmd
`default_nettype wire

/* File: rtl/fbsc_svc_map.sv */
// Maps message accesses to fieldbus service codes.
// Assumes the requester gives its own code for generic services.
`timescale 1ns/1ps
`default_nettype none
module fbsc_svc_map
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       msg_valid,
  input  wire logic [1:0] msg_access,
  input  wire logic [7:0] msg_svc_in,
  output logic            svc_valid_r,
  output logic [7:0]      svc_code_r
);

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      svc_valid_r <= 1'b0;
      svc_code_r  <= 8'h00;
    end
    else
    begin
      svc_valid_r <= msg_valid;
      case (msg_access)
        fbsc_pkg::ACC_READ:  svc_code_r <= fbsc_pkg::SVC_GET_SINGLE;
        fbsc_pkg::ACC_WRITE: svc_code_r <= fbsc_pkg::SVC_SET_SINGLE;
        default:             svc_code_r <= msg_svc_in;
      endcase
    end
  end

  a_svc_read_map : assert property (@(posedge core_clk) disable iff (rst)
    msg_valid && msg_access == fbsc_pkg::ACC_READ |=>
    svc_valid_r && svc_code_r == fbsc_pkg::SVC_GET_SINGLE)
    else $error("Read access not mapped to get service.");

endmodule : fbsc_svc_map
`default_nettype wire

/* File: rtl/fbsc_ctrl.sv */
// Fieldbus state and configuration controller, master and slave variant.
// Assumes the host presents state requests and object writes as strobes.
//
// Operation
// - In safe operational, update inputs and never write outputs.
// - In operational, update inputs and write outputs.
// - Mapping visible only after both parameter sets; then build image.
// - Master registers on bus and checks duplicate address after write.
// - Master starts slave traffic and allocates modes entering safe state.
// - Master idle in safe operational, run on entering operational.
// - Master reconfigures only after return to idle or pre-operational.
// - Slave registers on bus and checks duplicate address after write.
// - Slave becomes ready for a master entering safe operational.
// - Slave idle in safe operational, run on entering operational.
// - Slave reconfigures after return to idle or pre-operational.
// - Node address byte ranges from zero to the maximum.
// - Baud code is 1, 2 or 3.
// - Report applied address and baud in general object entries.
// - Stored setting persists and blocks writes to address entries.
// - All-zero command erases stored address and baud.
// - Get and set map without service code; others need one.
`timescale 1ns/1ps
`default_nettype none
module fbsc_ctrl
#(
  parameter bit IS_MASTER = 1'b1
)
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        state_req_valid,
  input  wire logic [3:0]  state_req,
  input  wire logic        obj_wr_valid,
  input  wire logic [15:0] obj_index,
  input  wire logic [7:0]  obj_sub,
  input  wire logic [15:0] obj_data,
  output logic             obj_wr_ack,
  output logic             obj_wr_refused,
  input  wire logic        cmd_valid,
  input  wire logic [19:0] command_index_group,
  input  wire logic [31:0] cmd_offset,
  input  wire logic [7:0]  cmd_len,
  input  wire logic [47:0] cmd_data,
  output logic             cmd_ok,
  output logic             cmd_bad,
  input  wire logic        msg_valid,
  input  wire logic [1:0]  msg_access,
  input  wire logic [7:0]  msg_svc_in,
  output logic             svc_valid_r,
  output logic [7:0]       svc_code_r,
  input  wire logic        dup_check_done,
  output logic [3:0]       link_state_r,
  output logic             register_req_r,
  output logic             dup_check_busy_r,
  output logic             mapping_ready_r,
  output logic             image_build_r,
  output logic             bus_start_r,
  output logic             bus_run_r,
  output logic             inputs_update_r,
  output logic             outputs_write_r,
  output logic [7:0]       node_address_r,
  output logic [7:0]       baud_r
);

  fbsc_pkg::fbsc_link_type st_r;
  fbsc_pkg::fbsc_link_type st_nxt;
  logic       gen_done_r;
  logic       slv_done_r;
  logic [7:0] wr_addr_r;
  logic [7:0] wr_baud_r;
  logic       stored_valid;
  logic [7:0] stored_addr;
  logic [7:0] stored_baud;
  logic       is_gen;
  logic       is_slv;
  logic       cfg_wr;
  logic       locked_entry;
  logic       to_safe;
  logic       to_op;
  logic       leave_cfg;

  fbsc_addr_cmd u_cmd
  (
    .core_clk            (core_clk),
    .rst                 (rst),
    .cmd_valid           (cmd_valid),
    .command_index_group (command_index_group),
    .cmd_offset          (cmd_offset),
    .cmd_len             (cmd_len),
    .cmd_data            (cmd_data),
    .cmd_ok              (cmd_ok),
    .cmd_bad             (cmd_bad),
    .stored_valid_r      (stored_valid),
    .stored_addr_r       (stored_addr),
    .stored_baud_r       (stored_baud)
  );

  fbsc_svc_map u_svc
  (
    .core_clk    (core_clk),
    .rst         (rst),
    .msg_valid   (msg_valid),
    .msg_access  (msg_access),
    .msg_svc_in  (msg_svc_in),
    .svc_valid_r (svc_valid_r),
    .svc_code_r  (svc_code_r)
  );

  function automatic logic is_slave_obj(input logic [15:0] idx);
    if (IS_MASTER)
      is_slave_obj = (idx & fbsc_pkg::OBJ_SLAVE_MASK)
                     == fbsc_pkg::OBJ_SLAVE_BASE;
    else
      is_slave_obj = idx == fbsc_pkg::OBJ_SLAVE_BASE;
  endfunction : is_slave_obj

  assign is_gen = obj_index == fbsc_pkg::OBJ_GENERAL;
  assign is_slv = is_slave_obj(obj_index);
  assign cfg_wr = obj_wr_valid && (is_gen || is_slv);
  // Address entries are frozen once a command has stored a setting.
  assign locked_entry = stored_valid &&
    ((is_gen && (obj_sub == fbsc_pkg::SUB_ADDR ||
                 obj_sub == fbsc_pkg::SUB_BAUD)) ||
     (is_slv && obj_sub == fbsc_pkg::SUB_ADDR));
  // Writes outside pre-operational are refused to keep the live set intact.
  assign obj_wr_refused = cfg_wr &&
    (st_r != fbsc_pkg::FBSC_ST_PREOP || locked_entry);
  assign obj_wr_ack = cfg_wr && !obj_wr_refused;

  // Host state requests follow the usual ladder; illegal jumps are ignored.
  always_comb
  begin
    st_nxt = st_r;
    if (state_req_valid)
    begin
      case (st_r)
        fbsc_pkg::FBSC_ST_INIT:
          if (state_req == fbsc_pkg::FBSC_ST_PREOP)
            st_nxt = fbsc_pkg::FBSC_ST_PREOP;
        fbsc_pkg::FBSC_ST_PREOP:
          if (state_req == fbsc_pkg::FBSC_ST_SAFEOP && mapping_ready_r)
            st_nxt = fbsc_pkg::FBSC_ST_SAFEOP;
          else if (state_req == fbsc_pkg::FBSC_ST_INIT)
            st_nxt = fbsc_pkg::FBSC_ST_INIT;
        fbsc_pkg::FBSC_ST_SAFEOP:
          if (state_req == fbsc_pkg::FBSC_ST_OP)
            st_nxt = fbsc_pkg::FBSC_ST_OP;
          else if (state_req == fbsc_pkg::FBSC_ST_PREOP ||
                   state_req == fbsc_pkg::FBSC_ST_INIT)
            st_nxt = fbsc_pkg::fbsc_link_type'(state_req);
        fbsc_pkg::FBSC_ST_OP:
          if (state_req != fbsc_pkg::FBSC_ST_OP &&
              (state_req == fbsc_pkg::FBSC_ST_SAFEOP ||
               state_req == fbsc_pkg::FBSC_ST_PREOP ||
               state_req == fbsc_pkg::FBSC_ST_INIT))
            st_nxt = fbsc_pkg::fbsc_link_type'(state_req);
        default:
          st_nxt = fbsc_pkg::FBSC_ST_INIT;
      endcase
    end
  end

  assign to_safe = st_r == fbsc_pkg::FBSC_ST_PREOP &&
                   st_nxt == fbsc_pkg::FBSC_ST_SAFEOP;
  assign to_op = st_r == fbsc_pkg::FBSC_ST_SAFEOP &&
                 st_nxt == fbsc_pkg::FBSC_ST_OP;
  assign leave_cfg = st_nxt == fbsc_pkg::FBSC_ST_INIT ||
                     (st_nxt == fbsc_pkg::FBSC_ST_PREOP &&
                      st_r != fbsc_pkg::FBSC_ST_PREOP);

  always_ff @(posedge core_clk)
  begin
    if (rst)
      st_r <= fbsc_pkg::FBSC_ST_INIT;
    else
      st_r <= st_nxt;
  end

  // Parameter sets must be rewritten after every return to configuration.
  always_ff @(posedge core_clk)
  begin
    if (rst || leave_cfg)
    begin
      gen_done_r <= 1'b0;
      slv_done_r <= 1'b0;
      wr_addr_r  <= 8'h00;
      wr_baud_r  <= 8'h00;
    end
    else if (obj_wr_ack)
    begin
      if (is_gen)
        gen_done_r <= 1'b1;
      if (is_slv)
        slv_done_r <= 1'b1;
      if (is_gen && obj_sub == fbsc_pkg::SUB_ADDR)
        wr_addr_r <= obj_data[7:0];
      if (is_gen && obj_sub == fbsc_pkg::SUB_BAUD)
        wr_baud_r <= obj_data[7:0];
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst || leave_cfg)
    begin
      mapping_ready_r <= 1'b0;
      image_build_r   <= 1'b0;
    end
    else
    begin
      mapping_ready_r <= gen_done_r && slv_done_r;
      image_build_r   <= gen_done_r && slv_done_r && !mapping_ready_r;
    end
  end

  // Registration starts once on the general object write.
  always_ff @(posedge core_clk)
  begin
    if (rst || leave_cfg)
    begin
      register_req_r   <= 1'b0;
      dup_check_busy_r <= 1'b0;
    end
    else
    begin
      register_req_r <= obj_wr_ack && is_gen && !gen_done_r;
      if (register_req_r)
        dup_check_busy_r <= 1'b1;
      else if (dup_check_done)
        dup_check_busy_r <= 1'b0;
    end
  end

  // Master starts slave traffic; slave becomes ready for its master.
  always_ff @(posedge core_clk)
  begin
    if (rst || leave_cfg)
    begin
      bus_start_r <= 1'b0;
      bus_run_r   <= 1'b0;
    end
    else
    begin
      if (to_safe)
        bus_start_r <= 1'b1;
      if (to_op)
        bus_run_r <= 1'b1;
      else if (st_nxt != fbsc_pkg::FBSC_ST_OP)
        bus_run_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      inputs_update_r <= 1'b0;
      outputs_write_r <= 1'b0;
    end
    else
    begin
      inputs_update_r <= st_nxt == fbsc_pkg::FBSC_ST_SAFEOP ||
                         st_nxt == fbsc_pkg::FBSC_ST_OP;
      outputs_write_r <= st_nxt == fbsc_pkg::FBSC_ST_OP;
    end
  end

  // Stored values apply only on the way from init, so the command waits; written values apply on entering safe operational if none is stored.
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      node_address_r <= 8'h00;
      baud_r         <= 8'h00;
    end
    else if (st_r == fbsc_pkg::FBSC_ST_INIT &&
             st_nxt == fbsc_pkg::FBSC_ST_PREOP && stored_valid)
    begin
      node_address_r <= stored_addr;
      baud_r         <= stored_baud;
    end
    else if (to_safe && !stored_valid)
    begin
      node_address_r <= wr_addr_r;
      baud_r         <= wr_baud_r;
    end
  end

  assign link_state_r = st_r;

  a_safe_no_out : assert property (@(posedge core_clk) disable iff (rst)
    st_r == fbsc_pkg::FBSC_ST_SAFEOP |-> !outputs_write_r && inputs_update_r)
    else $error("Outputs written in safe state.");

  a_op_writes : assert property (@(posedge core_clk) disable iff (rst)
    st_r == fbsc_pkg::FBSC_ST_OP |-> outputs_write_r && bus_run_r)
    else $error("Outputs not written in operational.");

  a_map_gate : assert property (@(posedge core_clk) disable iff (rst)
    mapping_ready_r |-> $past(gen_done_r) && $past(slv_done_r))
    else $error("Mapping visible too early.");

  sequence s_reg_then_busy;
    register_req_r ##1 dup_check_busy_r;
  endsequence
  a_reg_start : assert property (@(posedge core_clk) disable iff (rst)
    obj_wr_ack && is_gen && !gen_done_r && !leave_cfg |=> s_reg_then_busy)
    else $error("Registration not started.");

  a_start_bus : assert property (@(posedge core_clk) disable iff (rst)
    to_safe |=> bus_start_r && !bus_run_r)
    else $error("Bus not started in idle.");

  a_run_mode : assert property (@(posedge core_clk) disable iff (rst)
    to_op |=> bus_run_r)
    else $error("Run mode not entered.");

  a_reconf_clear : assert property (@(posedge core_clk) disable iff (rst)
    leave_cfg |=> !gen_done_r && !slv_done_r && !mapping_ready_r)
    else $error("Old configuration kept.");

  a_lock_entries : assert property (@(posedge core_clk) disable iff (rst)
    obj_wr_valid && locked_entry |-> obj_wr_refused && !obj_wr_ack)
    else $error("Locked entry written.");

  a_refuse_wr : assert property (@(posedge core_clk) disable iff (rst)
    cfg_wr && st_r != fbsc_pkg::FBSC_ST_PREOP |-> obj_wr_refused)
    else $error("Write accepted outside configuration.");

endmodule : fbsc_ctrl
`default_nettype wire

/* File: tb/fbsc_node_model.sv */
// Fieldbus node model that answers the duplicate address check.
// Assumes the controller holds dup_check_busy_r high while it checks.
`timescale 1ns/1ps
`default_nettype none
module fbsc_node_model
(
  input  wire logic       core_clk,
  input  wire logic [3:0] node_delay,
  input  wire logic       dup_check_busy_r,
  output logic            dup_check_done
);
  // The delay is an input so that one model can answer promptly or slowly.
  initial
  begin
    dup_check_done = 1'b0;
    forever
    begin
      @(posedge core_clk iff dup_check_busy_r);
      repeat (node_delay) @(posedge core_clk);
      dup_check_done <= 1'b1;
      @(posedge core_clk);
      dup_check_done <= 1'b0;
      @(posedge core_clk iff !dup_check_busy_r);
    end
  end
endmodule : fbsc_node_model
`default_nettype wire

/* File: tb/tb_top.sv */
// Testbench for the fieldbus state and configuration controller.
// Assumes the master variant and a node model on the fieldbus side.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        core_clk, rst, state_req_valid, obj_wr_valid;
  logic [3:0]  state_req, node_delay, link_state_r;
  logic [15:0] obj_index, obj_data;
  logic [7:0]  obj_sub, cmd_len, msg_svc_in, svc_code_r;
  logic [7:0]  node_address_r, baud_r;
  logic [19:0] command_index_group;
  logic [31:0] cmd_offset;
  logic [47:0] cmd_data;
  logic [1:0]  msg_access;
  logic        obj_wr_ack, obj_wr_refused, cmd_valid, cmd_ok, cmd_bad;
  logic        msg_valid, svc_valid_r, dup_check_done, register_req_r;
  logic        dup_check_busy_r, mapping_ready_r, image_build_r;
  logic        bus_start_r, bus_run_r, inputs_update_r, outputs_write_r;
  int          checks, fails;
  localparam logic [47:0] GOOD = 48'h0001_003c_2345;

  fbsc_ctrl #(.IS_MASTER(1'b1)) i_dut
  (
    .core_clk, .rst, .state_req_valid, .state_req, .obj_wr_valid,
    .obj_index, .obj_sub, .obj_data, .obj_wr_ack, .obj_wr_refused,
    .cmd_valid, .command_index_group, .cmd_offset, .cmd_len, .cmd_data,
    .cmd_ok, .cmd_bad, .msg_valid, .msg_access, .msg_svc_in,
    .svc_valid_r, .svc_code_r, .dup_check_done, .link_state_r,
    .register_req_r, .dup_check_busy_r, .mapping_ready_r, .image_build_r,
    .bus_start_r, .bus_run_r, .inputs_update_r, .outputs_write_r,
    .node_address_r, .baud_r
  );

  fbsc_node_model i_node
  (
    .core_clk, .node_delay, .dup_check_busy_r, .dup_check_done
  );

  task automatic chk(input string nm, input logic [15:0] exp,
                     input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic end_sim;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  task automatic do_reset;
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
  endtask : do_reset

  task automatic st(input logic [3:0] req, input logic [3:0] exp);
    @(posedge core_clk);
    state_req_valid <= 1'b1;
    state_req       <= req;
    @(posedge core_clk);
    state_req_valid <= 1'b0;
    @(negedge core_clk);
    chk("link_state_r", 16'(exp), 16'(link_state_r));
  endtask : st

  task automatic wr(input logic [15:0] idx, input logic [7:0] sub,
                    input logic [15:0] dat, input logic ack);
    @(posedge core_clk);
    obj_wr_valid <= 1'b1;
    obj_index    <= idx;
    obj_sub      <= sub;
    obj_data     <= dat;
    @(negedge core_clk);
    chk("obj_wr_ack", 16'(ack), 16'(obj_wr_ack));
    chk("obj_wr_refused", 16'(!ack), 16'(obj_wr_refused));
    @(posedge core_clk);
    obj_wr_valid <= 1'b0;
  endtask : wr

  // Code 2'b11 means an erase, where only the absence of cmd_bad is known.
  task automatic cmd(input logic [19:0] grp, input logic [7:0] len,
                     input logic [47:0] dat, input logic [1:0] exp);
    @(posedge core_clk);
    cmd_valid           <= 1'b1;
    command_index_group <= grp;
    cmd_len             <= len;
    cmd_data            <= dat;
    @(negedge core_clk);
    if (exp != 2'b11)
      chk("cmd_ok_bad", 16'(exp), 16'({cmd_ok, cmd_bad}));
    else
      chk("cmd_bad", 16'h0, 16'(cmd_bad));
    @(posedge core_clk);
    cmd_valid <= 1'b0;
  endtask : cmd

  task automatic msg(input logic [1:0] acc, input logic [7:0] svc,
                     input logic [7:0] exp);
    @(posedge core_clk);
    msg_valid  <= 1'b1;
    msg_access <= acc;
    msg_svc_in <= svc;
    @(posedge core_clk);
    msg_valid <= 1'b0;
    @(negedge core_clk);
    chk("svc_valid_r", 16'h1, 16'(svc_valid_r));
    chk("svc_code_r", 16'(exp), 16'(svc_code_r));
    @(negedge core_clk);
    chk("svc_valid_r", 16'h0, 16'(svc_valid_r));
  endtask : msg

  task automatic wait_idle;
    int n;
    n = 0;
    while (dup_check_busy_r !== 1'b0 && n < 40)
    begin
      @(negedge core_clk);
      n++;
    end
    chk("dup_check_busy_r", 16'h0, 16'(dup_check_busy_r));
  endtask : wait_idle

  task automatic t_start;
    chk("link_state_r", 16'h1, 16'(link_state_r));
    chk("mapping_ready_r", 16'h0, 16'(mapping_ready_r));
    wr(16'hf800, 8'h01, 16'h0005, 1'b0);
    st(4'h8, 4'h1);
    st(4'h2, 4'h2);
  endtask : t_start

  task automatic t_config;
    node_delay <= 4'h0;
    wr(fbsc_pkg::OBJ_GENERAL, 8'h01, 16'h0005, 1'b1);
    @(negedge core_clk);
    chk("register_req_r", 16'h1, 16'(register_req_r));
    @(negedge core_clk);
    chk("dup_check_busy_r", 16'h1, 16'(dup_check_busy_r));
    wait_idle;
    chk("mapping_ready_r", 16'h0, 16'(mapping_ready_r));
    node_delay <= 4'h6;
    wr(fbsc_pkg::OBJ_GENERAL, 8'h02, 16'h0002, 1'b1);
    wr(16'h8010, 8'h20, 16'h0002, 1'b1);
    @(negedge core_clk);
    chk("mapping_ready_r", 16'h0, 16'(mapping_ready_r));
    @(negedge core_clk);
    chk("mapping_ready_r", 16'h1, 16'(mapping_ready_r));
    chk("image_build_r", 16'h1, 16'(image_build_r));
    wait_idle;
  endtask : t_config

  task automatic t_run;
    st(4'h4, 4'h4);
    chk("bus_start_r", 16'h1, 16'(bus_start_r));
    chk("inputs_update_r", 16'h1, 16'(inputs_update_r));
    chk("outputs_write_r", 16'h0, 16'(outputs_write_r));
    chk("bus_run_r", 16'h0, 16'(bus_run_r));
    chk("node_address_r", 16'h5, 16'(node_address_r));
    chk("baud_r", 16'h2, 16'(baud_r));
    wr(16'h8010, 8'h20, 16'h0003, 1'b0);
    st(4'h8, 4'h8);
    chk("bus_run_r", 16'h1, 16'(bus_run_r));
    chk("outputs_write_r", 16'h1, 16'(outputs_write_r));
    chk("inputs_update_r", 16'h1, 16'(inputs_update_r));
    st(4'h2, 4'h2);
    chk("mapping_ready_r", 16'h0, 16'(mapping_ready_r));
    chk("bus_run_r", 16'h0, 16'(bus_run_r));
    st(4'h4, 4'h2);
  endtask : t_run

  task automatic t_addr;
    logic [47:0] d [6];
    logic [1:0]  e [6];
    d = '{48'h0003_003f_2345, 48'h0001_003c_2346, 48'h0001_0040_2345,
          48'h0000_003c_2345, 48'h0004_003c_2345, 48'h0001_013c_2345};
    e = '{2'b10, 2'b01, 2'b01, 2'b01, 2'b01, 2'b01};
    for (int i = 0; i < 6; i++)
      cmd(20'h1f480, 8'h06, d[i], e[i]);
    cmd(20'h1f481, 8'h06, GOOD, 2'b00);
    cmd(20'h1f480, 8'h05, GOOD, 2'b00);
    cmd_offset <= 32'h0000_0001;
    cmd(20'h1f480, 8'h06, GOOD, 2'b00);
    cmd_offset <= 32'h0000_0000;
    cmd(20'h1f480, 8'h06, GOOD, 2'b10);
    do_reset;
    st(4'h2, 4'h2);
    chk("node_address_r", 16'h3c, 16'(node_address_r));
    chk("baud_r", 16'h1, 16'(baud_r));
    wr(16'hf800, 8'h01, 16'h0009, 1'b0);
    wr(16'hf800, 8'h02, 16'h0003, 1'b0);
    wr(16'h8000, 8'h01, 16'h0009, 1'b0);
    cmd(20'h1f480, 8'h06, 48'h0, 2'b11);
    wr(16'hf800, 8'h01, 16'h0007, 1'b1);
    repeat (2) @(negedge core_clk);
    chk("dup_check_busy_r", 16'h1, 16'(dup_check_busy_r));
    wait_idle;
  endtask : t_addr

  task automatic t_service;
    msg(2'b00, 8'h55, fbsc_pkg::SVC_GET_SINGLE);
    msg(2'b01, 8'h55, fbsc_pkg::SVC_SET_SINGLE);
    msg(2'b10, 8'h4b, 8'h4b);
  endtask : t_service

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial
  begin
    repeat (3000) @(posedge core_clk);
    fails++;
    end_sim;
  end

  initial
  begin
    checks = 0;
    fails = 0;
    rst = 1'b1;
    state_req_valid = 1'b0;
    state_req = 4'h1;
    obj_wr_valid = 1'b0;
    obj_index = 16'h0;
    obj_sub = 8'h0;
    obj_data = 16'h0;
    cmd_valid = 1'b0;
    command_index_group = 20'h0;
    cmd_offset = 32'h0;
    cmd_len = 8'h0;
    cmd_data = 48'h0;
    msg_valid = 1'b0;
    msg_access = 2'b00;
    msg_svc_in = 8'h0;
    node_delay = 4'h0;
    do_reset;
    t_start;
    t_config;
    t_run;
    t_addr;
    t_service;
    end_sim;
  end
endmodule : tb_top
`default_nettype wire
